// *** design/rcc_unit.sv ***
// design: serial control command interpreter with 1:1 redundancy logic
`timescale 1ns/1ps
// Contract
// - control byte X, then one action letter
// - X O 1 drives switch to put us online
// - X P leaves mute, powers amplifier
// - X S mutes, disables amplifier
// - control commands get no response packet
// - link is 9600 baud, 7 data, even, 1 stop
// - one unit online, other on dummy load
// - online fault signals standby, standby takes over
// - fault with partner faulted/absent: no switching
// - alarm, serial command or knob cause transfer
// - reinstalled unit gets set-up, then goes online
// - auto switching can be off; alarms still reported
// - auto switch only online faulted, other standby
// - forced switch puts receiving unit online
// - muted unit unavailable as standby
// - sensed switch position sets online/standby status
// - manual switch change clears mute on both
// - faulted unit placed online switches back
// - request packet framing and address range
// - response packet framing; the unit has no transmitter and sends no responses
// - checksum is sum16(b-0x20) mod 0x5f plus 0x20
// - status bit1 standby, bit0 redundant
module rcc_unit #(
  parameter int unsigned BIT_CYCLES = rcc_pkg::BIT_CYC,
  parameter int unsigned DRIVE_CYCLES = rcc_pkg::DRIVE_CYC
) (
  input wire logic mclk_i,                // 125 MHz clock
  input wire logic resetn_i,              // async reset, active low
  input wire logic rxd_i,                 // serial receive line, idle high
  input wire logic [4:0] own_addr_i,      // unit address 0..16
  input wire logic redundant_i,           // fitted in a redundant pair
  input wire logic auto_en_i,             // automatic switching enabled
  input wire logic fault_i,               // own summary alarm
  input wire logic [6:0] alarms_i,        // other own alarm bits
  input wire logic wg_present_i,          // switch fitted
  input wire logic wg_online_i,           // switch routes us to antenna
  input wire rcc_pkg::rcc_peer_t nbr_i,   // neighbour status
  output rcc_pkg::rcc_peer_t self_o,      // our status to neighbour
  output logic wg_drive_o,                // drive switch toward us
  output logic mute_o,                    // amplifier stages disabled
  output logic online_o,                  // we are online
  output logic [7:0] alarm_status_byte_o, // alarm status byte
  output logic [7:0] redundancy_status_byte_o // redundancy status byte
);
  // ==========================================================
  // serial receiver, 7 data bits plus even parity plus stop
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_BITS = 2'b10,
    RX_STOP = 2'b11
  } rcc_rx_state_t;

  rcc_rx_state_t rx_state_reg;
  logic [13:0] rx_cnt_reg;
  logic [3:0] rx_idx_reg;
  logic [7:0] rx_sh_reg;
  rcc_pkg::rcc_char_t rx_char_reg;
  logic rx_stb_reg;
  logic rx_tick;

  assign rx_tick = (rx_cnt_reg == 14'h0000);

  // bit timing: half a bit to centre of start, then one bit per sample
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_state_reg <= RX_IDLE;
      rx_cnt_reg <= 14'h0000;
      rx_idx_reg <= 4'h0;
      rx_sh_reg <= 8'h00;
      rx_char_reg <= '0;
      rx_stb_reg <= 1'b0;
    end else begin
      rx_stb_reg <= 1'b0;
      if (!rx_tick) begin
        rx_cnt_reg <= rx_cnt_reg - 14'h0001;
      end
      unique case (rx_state_reg)
        RX_IDLE: begin
          if (!rxd_i) begin
            rx_state_reg <= RX_START;
            rx_cnt_reg <= 14'(BIT_CYCLES / 2 - 1);
          end
        end
        RX_START: begin
          if (rx_tick) begin
            // a glitch shorter than half a bit is not a start
            rx_state_reg <= rxd_i ? RX_IDLE : RX_BITS;
            rx_cnt_reg <= 14'(BIT_CYCLES - 1);
            rx_idx_reg <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_sh_reg <= {rxd_i, rx_sh_reg[7:1]}; // lsb first
            rx_cnt_reg <= 14'(BIT_CYCLES - 1);
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'(rcc_pkg::DATA_BITS)) begin
              rx_state_reg <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_char_reg.data <= rx_sh_reg[6:0];
            rx_char_reg.ok <= rxd_i && !(^rx_sh_reg);
            rx_stb_reg <= 1'b1;
            rx_state_reg <= RX_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // packet parser
  typedef enum logic [2:0] {
    PK_IDLE = 3'b000,
    PK_ADDR_HI = 3'b001,
    PK_ADDR_LO = 3'b010,
    PK_TAG = 3'b011,
    PK_CMD = 3'b100,
    PK_BODY = 3'b101,
    PK_CHECK = 3'b110
  } rcc_pk_state_t;

  rcc_pk_state_t pk_state_reg;
  logic [15:0] pk_sum_reg;
  logic [4:0] pk_addr_reg;
  logic pk_ctrl_reg;
  logic [1:0] pk_nbody_reg;
  logic [6:0] pk_letter_reg;
  logic [6:0] pk_param_reg;
  logic cmd_online_reg;
  logic cmd_unmute_reg;
  logic cmd_mute_reg;
  logic [6:0] c;
  logic [15:0] sum_add;
  logic [6:0] ck_expect;

  // checksum of everything up to and including the end mark
  function automatic logic [6:0] ck_of(input logic [15:0] s);
    logic [15:0] m;
    m = (s % rcc_pkg::CK_MOD) + rcc_pkg::CK_BIAS;
    return m[6:0];
  endfunction

  function automatic logic is_digit(input logic [6:0] d);
    return (d >= rcc_pkg::CH_ZERO) && (d <= rcc_pkg::CH_ZERO + 7'h09);
  endfunction

  assign c = rx_char_reg.data;
  assign sum_add = pk_sum_reg + {9'h000, c} - rcc_pkg::CK_BIAS;
  assign ck_expect = ck_of(pk_sum_reg);

  // framing; any bad character or a new start abandons the packet
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pk_state_reg <= PK_IDLE;
      pk_sum_reg <= 16'h0000;
      pk_addr_reg <= 5'h00;
      pk_ctrl_reg <= 1'b0;
      pk_nbody_reg <= 2'h0;
      pk_letter_reg <= 7'h00;
      pk_param_reg <= 7'h00;
      cmd_online_reg <= 1'b0;
      cmd_unmute_reg <= 1'b0;
      cmd_mute_reg <= 1'b0;
    end else begin
      cmd_online_reg <= 1'b0;
      cmd_unmute_reg <= 1'b0;
      cmd_mute_reg <= 1'b0;
      if (rx_stb_reg) begin
        pk_sum_reg <= sum_add;
        if (!rx_char_reg.ok) begin
          pk_state_reg <= PK_IDLE;
        end else if (c == rcc_pkg::CH_REQ_START &&
                     pk_state_reg != PK_CHECK) begin // check byte may be '<'
          pk_state_reg <= PK_ADDR_HI;
          pk_sum_reg <= {9'h000, c} - rcc_pkg::CK_BIAS;
        end else begin
          unique case (pk_state_reg)
            PK_IDLE: pk_state_reg <= PK_IDLE;
            PK_ADDR_HI: begin
              pk_addr_reg <= (c == rcc_pkg::CH_ONE) ? 5'h0a : 5'h00;
              pk_state_reg <= (is_digit(c) && c <= rcc_pkg::CH_ONE) ?
                              PK_ADDR_LO : PK_IDLE;
            end
            PK_ADDR_LO: begin
              pk_addr_reg <= pk_addr_reg + 5'(c - rcc_pkg::CH_ZERO);
              pk_state_reg <= is_digit(c) ? PK_TAG : PK_IDLE;
            end
            PK_TAG: begin
              pk_state_reg <= (c == rcc_pkg::CH_ADDR_TAG) ? PK_CMD : PK_IDLE;
            end
            PK_CMD: begin
              pk_ctrl_reg <= (c == rcc_pkg::CH_CTRL);
              pk_nbody_reg <= 2'h0;
              pk_letter_reg <= 7'h00;
              pk_param_reg <= 7'h00;
              pk_state_reg <= PK_BODY;
            end
            PK_BODY: begin
              if (c == rcc_pkg::CH_END) begin
                pk_state_reg <= PK_CHECK;
              end else begin
                if (pk_nbody_reg == 2'h0) begin
                  pk_letter_reg <= c;
                end else if (pk_nbody_reg == 2'h1) begin
                  pk_param_reg <= c;
                end
                if (pk_nbody_reg != 2'h3) begin
                  pk_nbody_reg <= pk_nbody_reg + 2'h1;
                end
              end
            end
            PK_CHECK: begin
              pk_state_reg <= PK_IDLE;
              if (c == ck_expect && pk_addr_reg == own_addr_i &&
                  pk_addr_reg <= rcc_pkg::ADDR_MAX && pk_ctrl_reg) begin
                unique case (pk_letter_reg)
                  rcc_pkg::CH_SET_SW: begin
                    cmd_online_reg <= pk_param_reg == rcc_pkg::CH_ONE;
                  end
                  rcc_pkg::CH_UNMUTE: cmd_unmute_reg <= 1'b1;
                  rcc_pkg::CH_MUTE: cmd_mute_reg <= 1'b1;
                  default: cmd_online_reg <= 1'b0;
                endcase
              end
            end
            default: pk_state_reg <= PK_IDLE;
          endcase
        end
      end
    end
  end
  // the unit has no transmitter: control packets are never answered
  // and no response framing is ever put on the line

  // ==========================================================
  // redundancy logic
  logic online_reg;
  logic online_d_reg;
  logic mute_reg;
  logic drive_reg;
  logic [22:0] drive_cnt_reg;
  logic wg_err_reg;
  logic setup_reg;
  logic nbr_present_d_reg;
  logic manual_chg;
  logic take_over;

  // a position change that neither unit commanded came from the knob
  assign manual_chg = (wg_online_i != online_d_reg) && !drive_reg &&
                      !nbr_i.drive;
  // standby takes over a faulted online partner, or one that hands it set-up
  assign take_over = !online_reg && !fault_i && !mute_reg &&
                     redundant_i && nbr_i.present &&
                     ((auto_en_i && nbr_i.fault) ||
                      nbr_i.setup);

  // switch position sets the online flag in a pair; a standalone unit is always online
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      online_reg <= 1'b0;
      online_d_reg <= 1'b0;
    end else begin
      online_reg <= redundant_i ? wg_online_i : 1'b1;
      online_d_reg <= wg_online_i;
    end
  end

  // mute: command sets or clears, a knob turn clears it in a pair
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mute_reg <= 1'b0;
    end else if (cmd_mute_reg) begin
      mute_reg <= 1'b1;
    end else if (cmd_unmute_reg || (manual_chg && redundant_i)) begin
      mute_reg <= 1'b0;
    end
  end

  // drive the switch toward us; only the gaining unit ever drives, and
  // a lone faulted survivor moves it only on an X O 1 command
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      drive_reg <= 1'b0;
      drive_cnt_reg <= 23'h000000;
      wg_err_reg <= 1'b0;
    end else if (drive_reg) begin
      if (wg_online_i) begin
        drive_reg <= 1'b0;
        wg_err_reg <= 1'b0;
      end else if (drive_cnt_reg == 23'h000000) begin
        drive_reg <= 1'b0; // give up: switch stuck or absent
        wg_err_reg <= 1'b1;
      end else begin
        drive_cnt_reg <= drive_cnt_reg - 23'h000001;
      end
    end else if (redundant_i && wg_present_i && !wg_online_i &&
                 (cmd_online_reg || take_over)) begin
      drive_reg <= 1'b1;
      drive_cnt_reg <= 23'(DRIVE_CYCLES - 1);
    end
  end

  // set-up for a reinstalled partner, held until it is online
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      setup_reg <= 1'b0;
      nbr_present_d_reg <= 1'b0;
    end else begin
      nbr_present_d_reg <= nbr_i.present;
      if (!nbr_i.present || !online_reg) begin
        setup_reg <= 1'b0;
      end else if (!nbr_present_d_reg) begin
        setup_reg <= 1'b1;
      end
    end
  end

  // outputs and status bytes; alarms reported in either mode
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      self_o <= '0;
      wg_drive_o <= 1'b0;
      mute_o <= 1'b0;
      online_o <= 1'b0;
      alarm_status_byte_o <= rcc_pkg::STAT_RST;
      redundancy_status_byte_o <= rcc_pkg::STAT_RST;
    end else begin
      self_o.fault <= fault_i;
      self_o.present <= 1'b1;
      self_o.muted <= mute_reg;
      self_o.drive <= drive_reg;
      self_o.setup <= setup_reg;
      wg_drive_o <= drive_reg;
      mute_o <= mute_reg;
      online_o <= online_reg;
      alarm_status_byte_o <= {mute_reg, alarms_i[6:3], fault_i,
                              alarms_i[1:0]};
      redundancy_status_byte_o <= {3'b000, wg_err_reg, wg_present_i,
                                   nbr_i.fault, !online_reg,
                                   redundant_i};
    end
  end
endmodule

// *** shared/rcc_pkg.sv ***
// package: constants and types for the redundancy control command unit
package rcc_pkg;
  // ==========================================================
  // clock and link timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned BAUD = 9600;
  localparam int unsigned BIT_CYC = CLK_HZ / BAUD;
  localparam int unsigned DATA_BITS = 7;
  localparam int unsigned DRIVE_TIMEOUT_MS = 50;
  localparam int unsigned DRIVE_CYC = (CLK_HZ / 1000) * DRIVE_TIMEOUT_MS;
  // ==========================================================
  // packet characters
  localparam logic [6:0] CH_REQ_START = 7'h3c;
  localparam logic [6:0] CH_RSP_START = 7'h3e;
  localparam logic [6:0] CH_ADDR_TAG = 7'h41;
  localparam logic [6:0] CH_CTRL = 7'h58;
  localparam logic [6:0] CH_SET_SW = 7'h4f;
  localparam logic [6:0] CH_UNMUTE = 7'h50;
  localparam logic [6:0] CH_MUTE = 7'h53;
  localparam logic [6:0] CH_ONE = 7'h31;
  localparam logic [6:0] CH_END = 7'h23;
  localparam logic [6:0] CH_ZERO = 7'h30;
  localparam logic [15:0] CK_BIAS = 16'h0020;
  localparam logic [15:0] CK_MOD = 16'h005f;
  localparam logic [4:0] ADDR_MAX = 5'h10;
  // ==========================================================
  // status byte fields
  localparam int unsigned RS_WG_ERR = 4;
  localparam int unsigned RS_WG_PRESENT = 3;
  localparam int unsigned RS_NBR_ALARM = 2;
  localparam int unsigned RS_STANDBY = 1;
  localparam int unsigned RS_REDUNDANT = 0;
  localparam int unsigned AS_MUTE = 7;
  localparam int unsigned AS_SUMMARY = 2;
  localparam logic [7:0] STAT_RST = 8'h00;
  // ==========================================================
  // types
  typedef struct packed {
    logic ok;         // stop bit and even parity good
    logic [6:0] data; // character
  } rcc_char_t;

  typedef struct packed {
    logic fault;   // summary alarm
    logic present; // unit fitted
    logic muted;   // unit muted
    logic drive;   // driving the switch
    logic setup;   // set-up handed over
  } rcc_peer_t;
endpackage

// *** tb/rcc_unit_sva.sv ***
// checker: switching, mute and status properties of the unit
`timescale 1ns/1ps
module rcc_unit_sva #(
  parameter int DRIVE_CYCLES = 64
) (
  input wire logic mclk_i, // clock
  input wire logic resetn_i, // reset, active low
  input wire logic redundant_i, // pair fitted
  input wire logic auto_en_i, // auto switching on
  input wire logic fault_i, // own alarm
  input wire logic wg_present_i, // switch fitted
  input wire logic wg_online_i, // switch position
  input wire rcc_pkg::rcc_peer_t nbr_i, // neighbour status
  input wire rcc_pkg::rcc_peer_t self_o, // our status
  input wire logic wg_drive_o, // switch drive
  input wire logic mute_o, // muted
  input wire logic online_o, // online
  input wire logic [7:0] alarm_status_byte_o, // alarm byte
  input wire logic [7:0] redundancy_status_byte_o // redundancy byte
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  // ==========================================================
  // helper logic
  logic tk;
  int dcnt_reg;
  // healthy standby facing a faulted online partner
  assign tk = !online_o && !fault_i && !mute_o && redundant_i &&
    nbr_i.present && auto_en_i && nbr_i.fault && wg_present_i &&
    !wg_online_i;
  // length of the current drive pulse, bounds a stuck switch
  always_ff @(posedge mclk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dcnt_reg <= 0;
    end else begin
      dcnt_reg <= wg_drive_o ? dcnt_reg + 1 : 0;
    end
  end
  // ==========================================================
  // properties
  mute_bit_a: assert property (alarm_status_byte_o[7] == mute_o)
    else $error("mute status bit differs from mute output");
  solo_drive_a: assert property ((!redundant_i)[*4] |-> !wg_drive_o)
    else $error("standalone unit drives the switch");
  online_drive_a: assert property (online_o[*3] |-> !wg_drive_o)
    else $error("online unit drives the switch");
  fault_take_a: assert property ($rose(wg_drive_o) |-> !$past(fault_i, 2))
    else $error("faulted unit took over");
  take_over_a: assert property ($rose(tk) ##1 tk |-> ##1 wg_drive_o)
    else $error("standby did not take over in time");
  drive_bound_a: assert property (dcnt_reg <= DRIVE_CYCLES + 4)
    else $error("switch drive held too long");
  online_track_a: assert property (
    (redundant_i && $stable(wg_online_i))[*4] |-> online_o == wg_online_i)
    else $error("online status does not follow the switch");
  standby_bit_a: assert property (
    (redundant_i && $stable(wg_online_i))[*4]
      |-> redundancy_status_byte_o[1] == !wg_online_i)
    else $error("standby bit wrong");
  fault_bit_a: assert property (
    $stable(fault_i)[*2] |-> alarm_status_byte_o[2] == fault_i)
    else $error("summary alarm bit differs from fault input");
  peer_fault_a: assert property ($stable(fault_i)[*2] |-> self_o.fault == fault_i)
    else $error("fault not passed to neighbour");
  manual_unmute_a: assert property (
    mute_o && $changed(wg_online_i) && !wg_drive_o && !nbr_i.drive
      |-> ##[1:8] !mute_o)
    else $error("manual switch change left unit muted");
endmodule

bind rcc_unit rcc_unit_sva #(.DRIVE_CYCLES(DRIVE_CYCLES)) u_rcc_unit_sva (
  .mclk_i, .resetn_i, .redundant_i, .auto_en_i, .fault_i, .wg_present_i,
  .wg_online_i, .nbr_i, .self_o, .wg_drive_o, .mute_o, .online_o,
  .alarm_status_byte_o, .redundancy_status_byte_o);

// *** tb/rcc_host.sv ***
// partner: host computer sending request packets on the serial line
`timescale 1ns/1ps
module rcc_host #(
  parameter int BIT_CYCLES = 16
) (
  input wire logic mclk_i, // bench clock
  output logic rxd_o // serial line to the unit
);
  // line idles at mark between characters
  initial rxd_o = 1'b1;
  // one character: start, 7 data lsb first, even parity, stop
  task automatic send_char(input logic [6:0] c);
    logic [9:0] f;
    f = {1'b1, ^c, c, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge mclk_i);
      #1 rxd_o = f[i];
      repeat (BIT_CYCLES - 1) @(posedge mclk_i);
    end
  endtask
  // whole request; returns at once since no answer ever comes
  task automatic send_pkt(input logic [4:0] a, input logic [2:0][6:0] b,
      input int n, input logic bad);
    logic [6:0] p[$];
    logic [15:0] s;
    p = {rcc_pkg::CH_REQ_START, 7'h30 + 7'(a / 10), 7'h30 + 7'(a % 10),
      rcc_pkg::CH_ADDR_TAG};
    for (int i = 0; i < n; i++) begin
      p.push_back(b[2 - i]);
    end
    p.push_back(rcc_pkg::CH_END);
    s = 16'h0000;
    foreach (p[i]) begin
      s += 16'(p[i]) - rcc_pkg::CK_BIAS;
    end
    s = (s % rcc_pkg::CK_MOD) + rcc_pkg::CK_BIAS;
    p.push_back(s[6:0] ^ {6'h00, bad});
    foreach (p[i]) begin
      send_char(p[i]);
    end
  endtask
endmodule

// *** tb/tb_top.sv ***
// testbench: serial commands and redundancy switching of the unit
`timescale 1ns/1ps
module tb_top;
  localparam int BC = 16;
  localparam int DC = 64;
  logic mclk_i, resetn_i, rxd, redundant, auto_en, fault, wg_present;
  logic wg_online, drive, mute, online, mute_q, drv_q;
  logic [4:0] addr;
  logic [6:0] alarms;
  logic [7:0] asb, rsb;
  logic [31:0] seed;
  rcc_pkg::rcc_peer_t nbr, self_s;
  int miscompares, cmp_count;
  logic exp_mute[$];
  logic exp_drv[$];
  rcc_unit #(.BIT_CYCLES(BC), .DRIVE_CYCLES(DC)) u_rcc_unit (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .rxd_i(rxd), .own_addr_i(addr),
    .redundant_i(redundant), .auto_en_i(auto_en), .fault_i(fault),
    .alarms_i(alarms), .wg_present_i(wg_present), .wg_online_i(wg_online),
    .nbr_i(nbr), .self_o(self_s), .wg_drive_o(drive), .mute_o(mute),
    .online_o(online), .alarm_status_byte_o(asb),
    .redundancy_status_byte_o(rsb));
  rcc_host #(.BIT_CYCLES(BC)) u_rcc_host (.mclk_i(mclk_i), .rxd_o(rxd));
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // control request X, letter, optional '1'; effect lands in a few edges
  task automatic cmd(input logic [6:0] l, input int n, input logic [4:0] a,
      input logic bad);
    u_rcc_host.send_pkt(a, {rcc_pkg::CH_CTRL, l, rcc_pkg::CH_ONE}, n, bad);
    tick(12);
  endtask
  // play the switch: follow the drive, then check the sensed status
  task automatic take_over();
    int i;
    i = 0;
    while (drive !== 1'b1 && i < 100) begin
      tick(1);
      i++;
    end
    wg_online = 1'b1;
    tick(20);
    chk("online", 8'h01, {7'h00, online});
  endtask
  // ==========================================================
  // clock, watchdog, monitor
  initial begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial begin
    repeat (60000) @(posedge mclk_i);
    miscompares++;
    test_done();
  end
  // each mute change and each drive rise takes the oldest note of its kind
  always @(posedge mclk_i) begin
    #2;
    if (resetn_i && mute !== mute_q) begin
      if (exp_mute.size() == 0) begin
        chk("mute unexpected", 8'h00, 8'h01);
      end else begin
        chk("mute", {7'h00, exp_mute.pop_front()}, {7'h00, mute});
      end
    end
    if (resetn_i && drive === 1'b1 && drv_q !== 1'b1) begin
      if (exp_drv.size() == 0) begin
        chk("drive unexpected", 8'h00, 8'h01);
      end else begin
        chk("drive", {7'h00, exp_drv.pop_front()}, 8'h01);
      end
    end
    mute_q = mute;
    drv_q = drive;
  end
  // ==========================================================
  // main sequence
  initial begin
    seed = xs(32'he4b6);
    resetn_i = 1'b0;
    redundant = 1'b0;
    auto_en = 1'b1;
    fault = 1'b0;
    wg_present = 1'b1;
    wg_online = 1'b0;
    nbr = '0;
    addr = 5'(seed % 17);
    alarms = seed[14:8];
    tick(8);
    resetn_i = 1'b1;
    tick(10);
    chk("solo status", 8'h08, rsb);
    chk("alarms", {1'b0, alarms[6:3], 1'b0, alarms[1:0]}, asb);
    redundant = 1'b1;
    nbr.present = 1'b1;
    tick(10);
    chk("pair status", 8'h0b, rsb);
    exp_mute.push_back(1'b1);
    cmd(rcc_pkg::CH_MUTE, 2, addr, 1'b0);
    cmd(rcc_pkg::CH_UNMUTE, 2, addr, 1'b1);
    cmd(rcc_pkg::CH_UNMUTE, 2, addr + 5'h01, 1'b0);
    cmd(7'h51, 2, addr, 1'b0);
    chk("mute bit", 8'h80, asb & 8'h80);
    exp_mute.push_back(1'b0);
    cmd(rcc_pkg::CH_UNMUTE, 2, addr, 1'b0);
    exp_mute.push_back(1'b1);
    exp_mute.push_back(1'b0);
    cmd(rcc_pkg::CH_MUTE, 2, addr, 1'b0);
    nbr.drive = 1'b1;
    wg_online = 1'b1;
    tick(20);
    chk("online", 8'h01, {7'h00, online});
    chk("mute kept", 8'h01, {7'h00, mute});
    nbr.drive = 1'b0;
    wg_online = 1'b0;
    tick(20);
    chk("mute cleared", 8'h00, {7'h00, mute});
    wg_present = 1'b0;
    cmd(rcc_pkg::CH_SET_SW, 3, addr, 1'b0);
    chk("no switch", 8'h00, {6'h00, rsb[3], drive});
    wg_present = 1'b1;
    tick(4);
    cmd(rcc_pkg::CH_SET_SW, 2, addr, 1'b0);
    exp_drv.push_back(1'b1);
    cmd(rcc_pkg::CH_SET_SW, 3, addr, 1'b0);
    tick(DC + 20);
    chk("drive timeout", 8'h10, {3'h0, rsb[4], 3'h0, drive});
    auto_en = 1'b0;
    nbr.fault = 1'b1;
    nbr.muted = 1'b1;
    tick(40);
    chk("nbr alarm", 8'h04, rsb & 8'h04);
    seed = xs(seed);
    alarms = seed[6:0];
    addr = 5'(seed % 17);
    auto_en = 1'b1;
    fault = 1'b1;
    tick(40);
    chk("fault alarms", {1'b0, alarms[6:3], 1'b1, alarms[1:0]}, asb);
    nbr.muted = 1'b0;
    exp_drv.push_back(1'b1);
    fault = 1'b0;
    take_over();
    nbr.fault = 1'b0;
    wg_online = 1'b0;
    tick(20);
    exp_mute.push_back(1'b1);
    cmd(rcc_pkg::CH_MUTE, 2, addr, 1'b0);
    nbr.fault = 1'b1;
    tick(40);
    exp_mute.push_back(1'b0);
    exp_drv.push_back(1'b1);
    cmd(rcc_pkg::CH_UNMUTE, 2, addr, 1'b0);
    take_over();
    nbr.fault = 1'b0;
    wg_online = 1'b0;
    auto_en = 1'b0;
    tick(20);
    exp_drv.push_back(1'b1);
    nbr.setup = 1'b1;
    take_over();
    nbr.setup = 1'b0;
    tick(20);
    chk("notes left", 8'h00, 8'(exp_mute.size() + exp_drv.size()));
    test_done();
  end
endmodule
